// >>> verilog/adc_ctrl_pkg.sv
// package: register map, field layout and constants of the converter control block
// assumes a 32-bit apb slave with byte addresses and one register per aligned word
package adc_ctrl_pkg;

   localparam int            ADDR_W      = 8;
   localparam int            DATA_W      = 32;
   localparam int            RESULT_W    = 10;
   localparam int            CLK_SEL_W   = 3;
   localparam int            REF_SEL_W   = 2;
   localparam int            DIV_W       = 7;
   localparam int            CNT_W       = 6;
   localparam int            SAMPLE_W    = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL_ZERO = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL_ONE  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RES_HIGH  = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_RES_LOW   = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STS   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h14;

   // converter_control_zero fields
   localparam int            BIT_ENABLE  = 0;
   localparam int            BIT_GO      = 1;
   // converter_control_one fields
   localparam int            BIT_FORMAT  = 7;
   localparam int            CLK_SEL_LSB = 4;
   localparam int            BIT_NEG_REF = 2;
   localparam int            POS_REF_LSB = 0;
   localparam logic [7:0]    CTRL_ONE_WMASK = 8'hF7;
   localparam logic [7:0]    CTRL_ONE_RESET = 8'h00;
   // interrupt fields
   localparam int            BIT_DONE    = 0;

   localparam logic [REF_SEL_W-1:0] POS_REF_FVR  = 2'h3;
   localparam logic [CLK_SEL_W-1:0] CLK_SEL_FRC  = 3'h7;
   localparam logic [SAMPLE_W-1:0]  SAMPLE_TICKS = 4'h2;

   // system clock division for each conversion clock code
   function automatic logic [DIV_W-1:0] clk_divisor(input logic [CLK_SEL_W-1:0] sel);
      logic [DIV_W-1:0] d;
      d = 7'h02;
      unique case (sel)
         3'h0: d = 7'h02;
         3'h1: d = 7'h08;
         3'h2: d = 7'h20;
         3'h4: d = 7'h04;
         3'h5: d = 7'h10;
         3'h6: d = 7'h40;
         default: d = 7'h02;
      endcase
      return d;
   endfunction

   // {high byte, low byte} of the result in the chosen justification
   function automatic logic [15:0] format_result(input logic [RESULT_W-1:0] r,
                                                 input logic right_just);
      if (right_just) begin
         return {6'h00, r};
      end
      return {r, 6'h00};
   endfunction

endpackage

// >>> verilog/conv_clock_gen.sv
// conversion clock tick generator: divided system clock or internal rc tick
// assumes rc_osc_tick is a one-cycle pulse already synchronous to clk
`timescale 1ns/10ps
module conv_clock_gen (
   input  wire logic                               clk,
   input  wire logic                               nrst,
   input  wire logic                               run,
   input  wire logic [adc_ctrl_pkg::CLK_SEL_W-1:0] sel,
   input  wire logic                               rc_osc_tick,
   output logic                                    tick
);
   import adc_ctrl_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [DIV_W-1:0] div_m1;

   assign div_m1 = clk_divisor(sel) - 7'h01;

   always_ff @(posedge clk) begin
      if (!nrst || !run) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (sel == CLK_SEL_FRC) begin
         cnt_q <= '0;
         tick  <= rc_osc_tick;
      end else if (cnt_q == div_m1[CNT_W-1:0]) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 6'h01;
         tick  <= 1'b0;
      end
   end

   a_rc_tick_pass: assert property (@(posedge clk) disable iff (!nrst)
      run && sel == CLK_SEL_FRC && rc_osc_tick |=> tick)
      else $error("rc tick not passed to conversion clock");

   a_div_two_rate: assert property (@(posedge clk) disable iff (!nrst)
      run && sel == 3'h0 && tick ##1 run && sel == 3'h0 |-> !tick ##1 (!run || sel != 3'h0 || tick))
      else $error("divide-by-two tick spacing wrong");

endmodule // conv_clock_gen

// >>> verilog/adc_conversion_control.sv
// converter control: apb registers, start/complete handshake, sar sequencing
// assumes an analog core with sample switch, code-driven dac and a comparator
`timescale 1ns/10ps

module adc_conversion_control (
   input  wire logic                               clk,
   input  wire logic                               nrst,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [adc_ctrl_pkg::DATA_W-1:0]    pwdata,
   output logic      [adc_ctrl_pkg::DATA_W-1:0]    prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   output logic                                    converter_enable,
   output logic                                    sample_hold,
   output logic                                    conv_active,
   output logic      [adc_ctrl_pkg::RESULT_W-1:0]  dac_code,
   input  wire logic                               comp_above,
   input  wire logic                               rc_osc_tick,
   output logic      [adc_ctrl_pkg::REF_SEL_W-1:0] positive_reference_select,
   output logic                                    fvr_ref_connect,
   output logic                                    negative_reference_select,
   output logic                                    irq
);
   import adc_ctrl_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_SAMPLE  = 3'b010,
      ST_CONVERT = 3'b100
   } conv_state_t;

   conv_state_t             state_q;
   logic                    enable_q;
   logic [7:0]              ctrl_one_q;
   logic [RESULT_W-1:0]     sar_q;
   logic [RESULT_W-1:0]     trial_q;
   logic [RESULT_W-1:0]     result_q;
   logic [RESULT_W-1:0]     kept;
   logic [SAMPLE_W-1:0]     sample_cnt_q;
   logic                    done_sts_q;
   logic                    done_msk_q;
   logic [DATA_W-1:0]       prdata_q;
   logic [DATA_W-1:0]       rd_d;
   logic [15:0]             res_fmt;
   logic                    busy;
   logic                    bus_wr;
   logic                    bus_setup;
   logic                    wr_ctrl_zero;
   logic                    start_req;
   logic                    abort_req;
   logic                    tick;
   logic                    sample_end;
   logic                    conv_done;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      return a == OFF_CTRL_ZERO || a == OFF_CTRL_ONE || a == OFF_RES_HIGH ||
             a == OFF_RES_LOW || a == OFF_IRQ_STS || a == OFF_IRQ_MASK;
   endfunction

   assign bus_wr       = psel && penable && pwrite;
   assign bus_setup    = psel && !penable;
   assign wr_ctrl_zero = bus_wr && paddr == OFF_CTRL_ZERO;
   assign busy         = state_q != ST_IDLE;

   // a start needs the enable written as one in the same word
   assign start_req = wr_ctrl_zero && pwdata[BIT_GO] && pwdata[BIT_ENABLE] &&
                      state_q == ST_IDLE;
   // clearing go or enable mid-conversion abandons it
   assign abort_req = busy && ((wr_ctrl_zero && (!pwdata[BIT_GO] || !pwdata[BIT_ENABLE]))
                               || !enable_q);

   assign sample_end = state_q == ST_SAMPLE && tick && sample_cnt_q == SAMPLE_TICKS - 4'h1;
   assign kept       = comp_above ? sar_q : (sar_q & ~trial_q);
   assign conv_done  = state_q == ST_CONVERT && tick && trial_q[0] && !abort_req;

   conv_clock_gen u_clk_gen (
      .clk         (clk),
      .nrst        (nrst),
      .run         (enable_q && busy),
      .sel         (ctrl_one_q[CLK_SEL_LSB +: CLK_SEL_W]),
      .rc_osc_tick (rc_osc_tick),
      .tick        (tick)
   );

   // control registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         enable_q   <= 1'b0;
         ctrl_one_q <= CTRL_ONE_RESET;
      end else begin
         if (wr_ctrl_zero) begin
            enable_q <= pwdata[BIT_ENABLE];
         end
         if (bus_wr && paddr == OFF_CTRL_ONE) begin
            ctrl_one_q <= pwdata[7:0] & CTRL_ONE_WMASK;
         end
      end
   end

   // conversion sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
      end else if (abort_req) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE:    if (start_req) state_q <= ST_SAMPLE;
            ST_SAMPLE:  if (sample_end) state_q <= ST_CONVERT;
            ST_CONVERT: if (conv_done) state_q <= ST_IDLE;
            default:    state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || start_req) begin
         sample_cnt_q <= '0;
      end else if (state_q == ST_SAMPLE && tick) begin
         sample_cnt_q <= sample_cnt_q + 4'h1;
      end
   end

   // successive approximation, msb first
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sar_q    <= '0;
         trial_q  <= '0;
         result_q <= '0;
      end else if (sample_end) begin
         sar_q   <= {1'b1, {(RESULT_W-1){1'b0}}};
         trial_q <= {1'b1, {(RESULT_W-1){1'b0}}};
      end else if (state_q == ST_CONVERT && tick) begin
         sar_q   <= kept | (trial_q >> 1);
         trial_q <= trial_q >> 1;
         if (conv_done) begin
            result_q <= kept;
         end
      end
   end

   // done flag: a new completion wins over a write-one clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_sts_q <= 1'b0;
         done_msk_q <= 1'b0;
      end else begin
         done_sts_q <= conv_done || (done_sts_q &&
                       !(bus_wr && paddr == OFF_IRQ_STS && pwdata[BIT_DONE]));
         if (bus_wr && paddr == OFF_IRQ_MASK) begin
            done_msk_q <= pwdata[BIT_DONE];
         end
      end
   end

   // read data latched in the setup phase, answered with no wait
   assign res_fmt = format_result(result_q, ctrl_one_q[BIT_FORMAT]);

   always_comb begin
      rd_d = '0;
      unique case (paddr)
         OFF_CTRL_ZERO: rd_d = {30'h0, busy, enable_q};
         OFF_CTRL_ONE:  rd_d = {24'h0, ctrl_one_q};
         OFF_RES_HIGH:  rd_d = {24'h0, res_fmt[15:8]};
         OFF_RES_LOW:   rd_d = {24'h0, res_fmt[7:0]};
         OFF_IRQ_STS:   rd_d = {31'h0, done_sts_q};
         OFF_IRQ_MASK:  rd_d = {31'h0, done_msk_q};
         default:       rd_d = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata_q <= '0;
      end else if (bus_setup && !pwrite) begin
         prdata_q <= rd_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit(paddr);

   assign converter_enable          = enable_q;
   assign sample_hold               = state_q == ST_SAMPLE;
   assign conv_active               = busy;
   assign dac_code                  = sar_q;
   assign positive_reference_select = ctrl_one_q[POS_REF_LSB +: REF_SEL_W];
   assign fvr_ref_connect           = positive_reference_select == POS_REF_FVR;
   assign negative_reference_select = ctrl_one_q[BIT_NEG_REF];
   assign irq                       = done_sts_q && done_msk_q;

   a_start_sets_busy: assert property (@(posedge clk) disable iff (!nrst)
      start_req |=> conv_active && sample_hold)
      else $error("start did not begin a conversion");

   a_done_clears_go: assert property (@(posedge clk) disable iff (!nrst)
      conv_done |=> !conv_active && done_sts_q)
      else $error("completion did not clear busy and flag done");

   a_done_only_end: assert property (@(posedge clk) disable iff (!nrst)
      $fell(conv_active) |-> $past(conv_done) || $past(abort_req))
      else $error("busy cleared without completion or abort");

   a_disable_stops: assert property (@(posedge clk) disable iff (!nrst)
      !converter_enable |-> !conv_active && !sample_hold)
      else $error("converter active while disabled");

   a_right_justify: assert property (@(posedge clk) disable iff (!nrst)
      bus_setup && !pwrite && paddr == OFF_RES_HIGH && ctrl_one_q[BIT_FORMAT]
      |=> prdata[7:2] == 6'h00 && prdata[1:0] == $past(result_q[9:8]))
      else $error("right-justified high byte wrong");

   a_left_justify: assert property (@(posedge clk) disable iff (!nrst)
      bus_setup && !pwrite && paddr == OFF_RES_LOW && !ctrl_one_q[BIT_FORMAT]
      |=> prdata[5:0] == 6'h00 && prdata[7:6] == $past(result_q[1:0]))
      else $error("left-justified low byte wrong");

   a_fvr_select: assert property (@(posedge clk) disable iff (!nrst)
      bus_wr && paddr == OFF_CTRL_ONE && pwdata[1:0] == 2'h3 |=> fvr_ref_connect)
      else $error("reference code 11 did not select fixed reference");

endmodule // adc_conversion_control

// >>> bench/analog_core_model.sv
// analog core stand-in: holds the sampled input, compares it with the trial code
// assumes control outputs of the converter block, all on clk
`timescale 1ns/10ps
module analog_core_model (
   input  wire logic                              clk,
   input  wire logic                              nrst,
   input  wire logic                              converter_enable,
   input  wire logic                              sample_hold,
   input  wire logic [adc_ctrl_pkg::RESULT_W-1:0] dac_code,
   input  wire logic [adc_ctrl_pkg::RESULT_W-1:0] vin,
   output logic                                   comp_above,
   output logic                                   rc_osc_tick
);
   import adc_ctrl_pkg::*;
   logic [RESULT_W-1:0] held_q;
   logic [1:0]          rc_q;
   always_ff @(posedge clk) begin
      if (sample_hold) begin
         held_q <= vin;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst || rc_q == 2'h2) begin
         rc_q <= 2'h0;
      end else begin
         rc_q <= rc_q + 2'h1;
      end
   end
   // unpowered core answers the wrong way round
   assign comp_above  = converter_enable ? (held_q >= dac_code) : (held_q < dac_code);
   assign rc_osc_tick = converter_enable && (rc_q == 2'h2);
endmodule // analog_core_model

// >>> bench/tb.sv
// testbench: apb register access, conversions over every clock code, interrupt
// assumes the converter block and the analog core model
`timescale 1ns/10ps
module tb;
   import adc_ctrl_pkg::*;
   logic                 clk, nrst, psel, penable, pwrite, err;
   logic [ADDR_W-1:0]    paddr;
   logic [DATA_W-1:0]    pwdata, prdata, rd;
   logic                 pready, pslverr, converter_enable, sample_hold, conv_active;
   logic                 comp_above, rc_osc_tick, fvr_ref_connect, neg_ref, irq;
   logic [RESULT_W-1:0]  dac_code, vin;
   logic [REF_SEL_W-1:0] pos_ref;
   int                   mismatches, comparisons;

   adc_conversion_control dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .converter_enable(converter_enable), .sample_hold(sample_hold),
      .conv_active(conv_active), .dac_code(dac_code), .comp_above(comp_above),
      .rc_osc_tick(rc_osc_tick), .positive_reference_select(pos_ref),
      .fvr_ref_connect(fvr_ref_connect), .negative_reference_select(neg_ref), .irq(irq));
   analog_core_model core (.clk(clk), .nrst(nrst), .converter_enable(converter_enable),
      .sample_hold(sample_hold), .dac_code(dac_code), .vin(vin), .comp_above(comp_above),
      .rc_osc_tick(rc_osc_tick));

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic convert(input logic [2:0] sel, input logic fmt, input logic [9:0] v);
      int n;
      vin <= v;
      apb(1'b1, OFF_CTRL_ONE, {24'h0, fmt, sel, 4'h0});
      apb(1'b1, OFF_CTRL_ZERO, 32'h3);
      apb(1'b0, OFF_CTRL_ZERO, 32'h0);
      chk("busy", 32'h3, rd);
      chk("enable_on", 32'h1, {31'h0, converter_enable});
      n = 0;
      do begin
         apb(1'b0, OFF_CTRL_ZERO, 32'h0);
         n++;
      end while (rd[1] !== 1'b0 && n < 400);
      chk("idle", 32'h1, rd);
      apb(1'b0, OFF_RES_HIGH, 32'h0);
      chk("res_high", fmt ? {30'h0, v[9:8]} : {24'h0, v[9:2]}, rd);
      apb(1'b0, OFF_RES_LOW, 32'h0);
      chk("res_low", fmt ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00}, rd);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (50000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, vin} = '0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, OFF_CTRL_ZERO, 32'h0);
      chk("ctrl0_reset", 32'h0, rd);
      apb(1'b0, OFF_CTRL_ONE, 32'h0);
      chk("ctrl1_reset", 32'h0, rd);
      apb(1'b1, OFF_CTRL_ONE, 32'hFF);
      apb(1'b0, OFF_CTRL_ONE, 32'h0);
      chk("ctrl1_rw", 32'hF7, rd);
      chk("mapped_err", 32'h0, {31'h0, err});
      chk("fvr_on", 32'h1, {31'h0, fvr_ref_connect});
      chk("pos_ref_fvr", 32'h3, {30'h0, pos_ref});
      chk("neg_ref_on", 32'h1, {31'h0, neg_ref});
      apb(1'b1, OFF_CTRL_ONE, 32'h02);
      @(negedge clk);
      chk("fvr_off", 32'h0, {31'h0, fvr_ref_connect});
      chk("pos_ref_two", 32'h2, {30'h0, pos_ref});
      chk("neg_ref_off", 32'h0, {31'h0, neg_ref});
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_data", 32'h0, rd);
      apb(1'b1, OFF_CTRL_ZERO, 32'h1);
      @(negedge clk);
      chk("enable_set", 32'h1, {31'h0, converter_enable});
      apb(1'b1, OFF_CTRL_ZERO, 32'h2);
      @(negedge clk);
      chk("enable_off", 32'h0, {31'h0, converter_enable});
      apb(1'b0, OFF_CTRL_ZERO, 32'h0);
      chk("go_disabled", 32'h0, rd);
      // start on the divide-by-two clock, rewrite go while busy, then drop enable
      apb(1'b1, OFF_CTRL_ZERO, 32'h3);
      apb(1'b1, OFF_CTRL_ZERO, 32'h3);
      apb(1'b0, OFF_CTRL_ZERO, 32'h0);
      chk("busy_kept", 32'h3, rd);
      apb(1'b1, OFF_CTRL_ZERO, 32'h2);
      apb(1'b0, OFF_CTRL_ZERO, 32'h0);
      chk("aborted", 32'h0, rd);
      repeat (40) @(posedge clk);
      apb(1'b0, OFF_IRQ_STS, 32'h0);
      chk("abort_no_done", 32'h0, rd);
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      for (int s = 0; s < 8; s++) begin
         convert(s[2:0], s[0], 10'h2A5 ^ 10'(s * 32'h49));
         @(negedge clk);
         chk("irq", 32'h1, {31'h0, irq});
         apb(1'b1, OFF_IRQ_STS, 32'h1);
         @(negedge clk);
         chk("irq_clear", 32'h0, {31'h0, irq});
      end
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      convert(CLK_SEL_FRC, 1'b1, 10'h3FF);
      apb(1'b0, OFF_IRQ_STS, 32'h0);
      chk("status_masked", 32'h1, rd);
      chk("irq_masked", 32'h0, {31'h0, irq});
      tally_and_finish();
   end
endmodule // tb
